// ==== phist_pkg.sv ====
package phist_pkg;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int TICK_NS       = 1000000;
    // Time base tick of 1 ms; exact multiple of the clock period
    localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

    // ==========================================================
    // Data path sizes
    localparam int SAMPLE_W   = 16;
    localparam int CNT_W      = 24;
    localparam int HIST_AW    = 13;
    localparam int HIST_DEPTH = 8192;
    localparam int FILT_TAPS  = 4;
    localparam int FILT_SHIFT = 2;

    localparam logic [15:0] FULL_SCALE_CODE = 16'hFFFF;
    localparam logic [23:0] CNT_MAX         = 24'hFFFFFF;
    localparam int          FULL_SCALE_MV   = 1000;
    localparam int          MIN_HEIGHT_MV   = 5;
    localparam int          MIN_HEIGHT_CODE = MIN_HEIGHT_MV * 65536 / FULL_SCALE_MV;
    localparam logic [15:0] LFSR_SEED       = 16'hACE1;

    // ==========================================================
    // Register byte offsets
    localparam logic [15:0] REG_CTRL      = 16'h0000;
    localparam logic [15:0] REG_THRESH    = 16'h0004;
    localparam logic [15:0] REG_FLOOR     = 16'h0008;
    localparam logic [15:0] REG_STATUS    = 16'h000C;
    localparam logic [15:0] REG_REAL_TIME = 16'h0010;
    localparam logic [15:0] REG_LIVE_TIME = 16'h0014;
    localparam logic [15:0] REG_TOTAL     = 16'h0018;
    localparam logic [15:0] REG_LAST_PEAK = 16'h001C;
    localparam logic [15:0] HIST_BASE     = 16'h8000;

    // ==========================================================
    // Control fields
    localparam int CTRL_ACQ      = 0;
    localparam int CTRL_RANGE    = 1;
    localparam int CTRL_MODE     = 2;
    localparam int CTRL_CHSEL_LO = 3;
    localparam int CTRL_SYNC_LO  = 6;
    localparam int CTRL_VETO_LO  = 8;
    localparam int CTRL_CLEAR    = 10;
    localparam int CTRL_W        = 10;

    localparam logic [9:0]  CTRL_RESET   = 10'h000;
    localparam logic [15:0] THRESH_RESET = 16'h0148;
    localparam logic [15:0] FLOOR_RESET  = 16'h0000;
    localparam logic [2:0]  CHSEL_MAX    = 3'h5;
    localparam logic [3:0]  SHIFT_BASE   = 4'h8;

    typedef enum logic [1:0] {GATE_OFF, GATE_HIGH, GATE_LOW} gate_mode_t;
    typedef enum logic {MODE_SEPARATE, MODE_ABSOLUTE} peak_mode_t;
    typedef enum logic {PK_IDLE, PK_TRACK} peak_state_t;

endpackage

// ==== sample_smoother.sv ====
`timescale 1ns/1ps

module sample_smoother
    import phist_pkg::*;
(
    // Clock and reset
    input  wire logic                mclk,
    input  wire logic                sys_rst,
    // Raw samples
    input  wire logic                in_valid,
    input  wire logic [SAMPLE_W-1:0] in_data,
    // Smoothed samples
    output logic                     out_valid,
    output logic [SAMPLE_W-1:0]      out_data
);

    logic [SAMPLE_W-1:0]       tap_q [FILT_TAPS];
    logic [SAMPLE_W+1:0]       sum_d;

    always_comb
    begin
        sum_d = {2'b00, in_data};
        for (int i = 0; i < FILT_TAPS - 1; i++)
        begin
            sum_d = sum_d + {2'b00, tap_q[i]};
        end
    end

    // ==========================================================
    // Boxcar average: trades a few cycles of latency for less jitter
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < FILT_TAPS; i++)
            begin
                tap_q[i] <= '0;
            end
            out_valid <= 1'b0;
            out_data  <= '0;
        end
        else
        begin
            out_valid <= in_valid;
            if (in_valid)
            begin
                tap_q[0] <= in_data;
                for (int i = 1; i < FILT_TAPS; i++)
                begin
                    tap_q[i] <= tap_q[i-1];
                end
                out_data <= sum_d[SAMPLE_W+FILT_SHIFT-1:FILT_SHIFT];
            end
        end
    end

endmodule

// ==== pulse_peak_histogrammer.sv ====
`timescale 1ns/1ps


module pulse_peak_histogrammer
    import phist_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYCLES
)
(
    // Clock and reset
    input  wire logic                mclk,
    input  wire logic                sys_rst,
    // Converter samples
    input  wire logic                adc_valid,
    input  wire logic [SAMPLE_W-1:0] adc_data,
    // Gates
    input  wire logic                sync_gate_input,
    input  wire logic                veto_gate_input,
    // Attenuator select
    output logic                     atten_sel,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [15:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic [31:0]              prdata,
    output logic                     pready,
    output logic                     pslverr
);

    logic [CTRL_W-1:0]   ctrl_q;
    logic [15:0]         thr_q;
    logic [15:0]         floor_q;
    logic                filt_v;
    logic [15:0]         filt;
    peak_state_t         pk_st_q;
    logic [15:0]         max_q;
    logic                rep_q;
    logic                peak_v_q;
    logic [15:0]         peak_q;
    logic [15:0]         lfsr_q;
    logic                acc_q;
    logic [HIST_AW-1:0]  ch_q;
    logic                inc_q;
    logic [HIST_AW-1:0]  inc_addr_q;
    logic [CNT_W-1:0]    hist_mem [HIST_DEPTH];
    logic [CNT_W-1:0]    mem_q;
    logic [HIST_AW-1:0]  rd_addr;
    logic                clr_busy_q;
    logic [HIST_AW-1:0]  clr_idx_q;
    logic                hrd_q;
    logic [31:0]         tick_cnt_q;
    logic                tick_q;
    logic [31:0]         real_q;
    logic [31:0]         live_q;
    logic [31:0]         total_q;
    logic [15:0]         last_q;
    logic                wr_en;
    logic                clr_cmd;
    logic                is_hist;
    logic                mapped;
    logic [31:0]         rd_mux;
    peak_mode_t          mode;
    logic                gates_ok;
    logic                acq_en;
    logic [2:0]          chsel;
    logic [3:0]          shift;
    logic [15:0]         dmask;
    logic [16:0]         lin17;
    logic [15:0]         lin;
    logic [15:0]         idx16;
    logic [16:0]         drop;

    function automatic logic gate_pass(input logic [1:0] m, input logic lvl);
        gate_mode_t gm;
        gm = gate_mode_t'(m);
        case (gm)
            GATE_HIGH: gate_pass = lvl;
            GATE_LOW:  gate_pass = ~lvl;
            default:   gate_pass = 1'b1;
        endcase
    endfunction

    assign mode   = peak_mode_t'(ctrl_q[CTRL_MODE]);
    assign acq_en = ctrl_q[CTRL_ACQ];
    // Pile-up veto works by holding a gate inactive around overlaps
    assign gates_ok = gate_pass(ctrl_q[CTRL_SYNC_LO +: 2], sync_gate_input)
                    & gate_pass(ctrl_q[CTRL_VETO_LO +: 2], veto_gate_input);

    // ==========================================================
    // Register writes
    assign wr_en   = psel & penable & pready & pwrite & ~pslverr;
    assign clr_cmd = wr_en & (paddr == REG_CTRL) & pwdata[CTRL_CLEAR];

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            ctrl_q    <= CTRL_RESET;
            thr_q     <= THRESH_RESET;
            floor_q   <= FLOOR_RESET;
            atten_sel <= 1'b0;
        end
        else
        begin
            if (wr_en && paddr == REG_CTRL)
            begin
                ctrl_q <= pwdata[CTRL_W-1:0];
            end
            if (wr_en && paddr == REG_THRESH)
            begin
                thr_q <= pwdata[15:0];
            end
            if (wr_en && paddr == REG_FLOOR)
            begin
                floor_q <= pwdata[15:0];
            end
            atten_sel <= ctrl_q[CTRL_RANGE];
        end
    end

    // ==========================================================
    // Filtering
    sample_smoother u_smooth
    (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .in_valid  (adc_valid),
        .in_data   (adc_data),
        .out_valid (filt_v),
        .out_data  (filt)
    );

    // ==========================================================
    // Peak detector
    // Threshold is in converter codes; its reset value 0x148 sits one code above the smallest pulse height (MIN_HEIGHT_CODE, 0x147)
    assign drop = {1'b0, max_q} - {1'b0, filt};

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            pk_st_q  <= PK_IDLE;
            max_q    <= '0;
            rep_q    <= 1'b0;
            peak_v_q <= 1'b0;
            peak_q   <= '0;
        end
        else
        begin
            peak_v_q <= 1'b0;
            if (filt_v)
            begin
                case (pk_st_q)
                    PK_IDLE:
                    begin
                        if (filt > thr_q)
                        begin
                            pk_st_q <= PK_TRACK;
                            max_q   <= filt;
                            rep_q   <= 1'b0;
                        end
                    end
                    PK_TRACK:
                    begin
                        if (filt <= thr_q)
                        begin
                            pk_st_q <= PK_IDLE;
                            if (mode == MODE_ABSOLUTE)
                            begin
                                peak_v_q <= 1'b1;
                                peak_q   <= max_q;
                            end
                        end
                        else if (filt > max_q)
                        begin
                            max_q <= filt;
                            rep_q <= 1'b0;
                        end
                        else if (mode == MODE_SEPARATE)
                        begin
                            if (!rep_q && drop >= {1'b0, thr_q})
                            begin
                                peak_v_q <= 1'b1;
                                peak_q   <= max_q;
                                rep_q    <= 1'b1;
                                max_q    <= filt;
                            end
                            else if (rep_q)
                            begin
                                // Follow the valley so the next rise counts
                                max_q <= filt;
                            end
                        end
                    end
                    default:
                    begin
                        pk_st_q <= PK_IDLE;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Linearization and channel index
    assign chsel = (ctrl_q[CTRL_CHSEL_LO +: 3] > CHSEL_MAX) ? CHSEL_MAX
                 : ctrl_q[CTRL_CHSEL_LO +: 3];
    assign shift = SHIFT_BASE - {1'b0, chsel};
    assign dmask = ~(16'hFFFF << shift);
    // Dither spreads each code over neighbouring channels
    assign lin17 = {1'b0, peak_q} + {1'b0, lfsr_q & dmask};
    assign lin   = lin17[16] ? FULL_SCALE_CODE : lin17[15:0];
    assign idx16 = lin >> shift;

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            lfsr_q <= LFSR_SEED;
        end
        else
        begin
            lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[14] ^ lfsr_q[12] ^ lfsr_q[3]};
        end
    end

    // ==========================================================
    // Acceptance and binning
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            acc_q      <= 1'b0;
            ch_q       <= '0;
            inc_q      <= 1'b0;
            inc_addr_q <= '0;
            last_q     <= '0;
        end
        else
        begin
            acc_q <= peak_v_q & acq_en & gates_ok & ~clr_busy_q
                   & (peak_q > floor_q) & (peak_q != FULL_SCALE_CODE);
            ch_q       <= idx16[HIST_AW-1:0];
            inc_q      <= acc_q;
            inc_addr_q <= ch_q;
            if (peak_v_q)
            begin
                last_q <= peak_q;
            end
        end
    end

    // Binning owns the read port; bus reads wait a cycle behind it
    assign rd_addr = acc_q ? ch_q : paddr[HIST_AW+1:2];

    always_ff @(posedge mclk)
    begin
        mem_q <= hist_mem[rd_addr];
        if (clr_busy_q)
        begin
            hist_mem[clr_idx_q] <= '0;
        end
        else if (inc_q)
        begin
            hist_mem[inc_addr_q] <= (mem_q == CNT_MAX) ? CNT_MAX : mem_q + 1'b1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            clr_busy_q <= 1'b0;
            clr_idx_q  <= '0;
        end
        else if (clr_cmd)
        begin
            clr_busy_q <= 1'b1;
            clr_idx_q  <= '0;
        end
        else if (clr_busy_q)
        begin
            clr_idx_q <= clr_idx_q + 1'b1;
            if (&clr_idx_q)
            begin
                clr_busy_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Real, live and count timers
    always_ff @(posedge mclk)
    begin
        if (sys_rst || clr_cmd)
        begin
            tick_cnt_q <= '0;
            tick_q     <= 1'b0;
            real_q     <= '0;
            live_q     <= '0;
            total_q    <= '0;
        end
        else
        begin
            tick_q <= 1'b0;
            if (acq_en)
            begin
                if (tick_cnt_q == 32'(TICK_CYC - 1))
                begin
                    tick_cnt_q <= '0;
                    tick_q     <= 1'b1;
                end
                else
                begin
                    tick_cnt_q <= tick_cnt_q + 1'b1;
                end
            end
            if (tick_q)
            begin
                real_q <= real_q + 1'b1;
                if (gates_ok)
                begin
                    live_q <= live_q + 1'b1;
                end
            end
            if (acc_q)
            begin
                total_q <= total_q + 1'b1;
            end
        end
    end

    // ==========================================================
    // APB read side
    assign is_hist = paddr[15];

    always_comb
    begin
        mapped = 1'b1;
        rd_mux = '0;
        case (paddr)
            REG_CTRL:      rd_mux = {22'h000000, ctrl_q};
            REG_THRESH:    rd_mux = {16'h0000, thr_q};
            REG_FLOOR:     rd_mux = {16'h0000, floor_q};
            REG_STATUS:    rd_mux = {29'h00000000, acq_en, pk_st_q == PK_TRACK, clr_busy_q};
            REG_REAL_TIME: rd_mux = real_q;
            REG_LIVE_TIME: rd_mux = live_q;
            REG_TOTAL:     rd_mux = total_q;
            REG_LAST_PEAK: rd_mux = {16'h0000, last_q};
            default:       mapped = 1'b0;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
            hrd_q   <= 1'b0;
        end
        else if (pready)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else if (hrd_q)
        begin
            hrd_q  <= 1'b0;
            pready <= 1'b1;
            prdata <= {8'h00, mem_q};
        end
        else if (psel)
        begin
            if (is_hist && !pwrite)
            begin
                hrd_q <= ~acc_q;
            end
            else
            begin
                pready  <= 1'b1;
                pslverr <= is_hist | ~mapped;
                prdata  <= (is_hist | pwrite) ? 32'h00000000 : rd_mux;
            end
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    property p_pos_only;
        peak_v_q |-> (peak_q > $past(thr_q));
    endproperty
    a_pos_only: assert property (p_pos_only) else $error("peak not above threshold");

    property p_sep_drop;
        (peak_v_q && mode == MODE_SEPARATE && $stable(thr_q))
            |-> ({1'b0, peak_q} - {1'b0, $past(filt)}) >= {1'b0, thr_q};
    endproperty
    a_sep_drop: assert property (p_sep_drop) else $error("peak before full drop");

    property p_abs_exit;
        (peak_v_q && mode == MODE_ABSOLUTE && $stable(thr_q)) |-> $past(filt) <= thr_q;
    endproperty
    a_abs_exit: assert property (p_abs_exit) else $error("absolute peak inside excursion");

    property p_gate_sampled;
        acc_q |-> $past(gates_ok) && $past(peak_v_q);
    endproperty
    a_gate_sampled: assert property (p_gate_sampled) else $error("gated peak accepted");

    property p_floor;
        (acc_q && $stable(floor_q)) |-> $past(peak_q) > floor_q;
    endproperty
    a_floor: assert property (p_floor) else $error("peak at or below floor");

    property p_overrange;
        acc_q |-> $past(peak_q) != FULL_SCALE_CODE;
    endproperty
    a_overrange: assert property (p_overrange) else $error("over-range peak binned");

    property p_bin_write;
        (acc_q && !clr_busy_q) |=> inc_q && inc_addr_q == $past(ch_q);
    endproperty
    a_bin_write: assert property (p_bin_write) else $error("accepted peak not binned");

    property p_live_gated;
        (tick_q && !gates_ok && !clr_cmd) |=> live_q == $past(live_q);
    endproperty
    a_live_gated: assert property (p_live_gated) else $error("live time ran while gated");

    property p_reg_answer;
        (psel && !penable && !pready && !hrd_q && !is_hist) |=> pready;
    endproperty
    a_reg_answer: assert property (p_reg_answer) else $error("register read not answered");

    property p_hist_answer;
        hrd_q |=> pready && !pslverr && prdata[31:24] == 8'h00;
    endproperty
    a_hist_answer: assert property (p_hist_answer) else $error("histogram read late");

    c_sep_peak: cover property (peak_v_q && mode == MODE_SEPARATE);
    c_abs_peak: cover property (peak_v_q && mode == MODE_ABSOLUTE);
    c_gated:    cover property (peak_v_q && !gates_ok);
    c_binned:   cover property (inc_q);

endmodule

// ==== adc_pulse_model.sv ====
`timescale 1ns/1ps

module adc_pulse_model (
    // Clock
    input  wire logic        mclk,
    // Pulse request: rise, dip, second top
    input  wire logic        start,
    input  wire logic [15:0] h1,
    input  wire logic [15:0] dip,
    input  wire logic [15:0] h2,
    // Converter side
    output logic             adc_valid = 1'b0,
    output logic [15:0]      adc_data = 16'h0000,
    output logic             busy
);
    int unsigned pos = 40;

    // ========
    // Sample stream
    // Baseline noise stays far below the threshold so it never reads as a pulse
    always @(posedge mclk)
    begin
        adc_valid <= 1'b1;
        if (start)
            pos <= 0;
        else if (pos < 40)
            pos <= pos + 1;
        if (pos < 6)
            adc_data <= h1;
        else if (pos < 12)
            adc_data <= dip;
        else if (pos < 18)
            adc_data <= h2;
        else
            adc_data <= 16'($urandom_range(0, 63));
    end

    assign busy = (pos < 40);
endmodule

// ==== tb.sv ====
`timescale 1ns/1ps

module tb;
    import phist_pkg::*;

    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        start = 1'b0;
    logic        sync_gate_input = 1'b0;
    logic        veto_gate_input = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [15:0] h1 = 16'h0000;
    logic [15:0] dip = 16'h0000;
    logic [15:0] h2 = 16'h0000;
    logic [31:0] prdata;
    logic [31:0] r;
    logic [31:0] t0;
    logic [31:0] t1;
    logic [15:0] adc_data;
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] c;
    logic [15:0] floor_lvl;
    logic [1:0]  sc;
    logic [1:0]  vc;
    logic [2:0]  chs;
    logic        pready, pslverr, adc_valid, atten_sel, busy, e;
    logic        m, sg, vg, dbl, rg;
    int          err_total = 0;
    int          n_checks = 0;
    int          i;

    always #20 mclk = ~mclk;

    adc_pulse_model adc (.mclk(mclk), .start(start), .h1(h1), .dip(dip), .h2(h2),
        .adc_valid(adc_valid), .adc_data(adc_data), .busy(busy));

    pulse_peak_histogrammer #(.TICK_CYC(10)) dut (.mclk(mclk), .sys_rst(sys_rst),
        .adc_valid(adc_valid), .adc_data(adc_data), .sync_gate_input(sync_gate_input),
        .veto_gate_input(veto_gate_input), .atten_sel(atten_sel), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // ========
    // Bus and compare tasks
    task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task apb(input logic w, input logic [15:0] ad, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
            chk(0, 1, "apb timeout");
    endtask

    task rd(input logic [15:0] ad, input logic [31:0] x, input string msg);
        apb(1'b0, ad, 32'h0);
        chk(r, x, msg);
    endtask

    // Waits on the model, then covers the fixed detect-to-bin latency
    task pulse(input logic [15:0] p1, input logic [15:0] pd, input logic [15:0] p2);
        int n;
        n = 0;
        h1 <= p1;
        dip <= pd;
        h2 <= p2;
        start <= 1'b1;
        @(posedge mclk);
        start <= 1'b0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (busy !== 1'b0 && n < 100);
        chk(busy, 1'b0, "model busy");
        repeat (12) @(posedge mclk);
    endtask

    // ========
    // Expectations
    function automatic logic pass(input logic [1:0] code, input logic lvl);
        return (code == 2'h1) ? lvl : (code == 2'h2) ? !lvl : 1'b1;
    endfunction

    function automatic logic [31:0] npk(input logic md, input logic two, input logic ok,
        input logic [15:0] p1, input logic [15:0] p2, input logic [15:0] fl);
        logic [31:0] k;
        k = 32'h0;
        if (ok && p2 > fl && p2 != 16'hFFFF)
            k++;
        if (ok && two && !md && p1 > fl)
            k++;
        return k;
    endfunction

    task results;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        repeat (40000) @(posedge mclk);
        err_total++;
        results;
    end

    // ========
    // Main sequence
    initial
    begin
        void'($urandom(32'h455A));
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        rd(REG_CTRL, 32'h0, "ctrl reset");
        rd(REG_THRESH, 32'h148, "thresh reset");
        rd(REG_FLOOR, 32'h0, "floor reset");
        rd(16'h0020, 32'h0, "unmapped");
        chk(e, 1, "unmapped err");
        apb(1'b1, HIST_BASE, 32'h1);
        chk(e, 1, "hist write err");
        apb(1'b1, REG_CTRL, 32'h400);
        i = 0;
        do
        begin
            apb(1'b0, REG_STATUS, 32'h0);
            i++;
        end
        while (r[0] !== 1'b0 && i < 5000);
        chk(r[0], 1'b0, "clear done");
        rd(REG_TOTAL, 32'h0, "cleared");
        // Dither may push the count into the next channel
        apb(1'b1, REG_CTRL, 32'h1);
        pulse(16'h4380, 16'h4380, 16'h4380);
        apb(1'b0, HIST_BASE + 16'h010C, 32'h0);
        t0 = r;
        apb(1'b0, HIST_BASE + 16'h0110, 32'h0);
        chk(t0 + r, 32'h1, "binned");
        apb(1'b1, REG_CTRL, 32'h41);
        apb(1'b0, REG_LIVE_TIME, 32'h0);
        t0 = r;
        apb(1'b0, REG_REAL_TIME, 32'h0);
        t1 = r;
        repeat (100) @(posedge mclk);
        rd(REG_LIVE_TIME, t0, "live held");
        // Ten-cycle tick in the bench: over 100 cycles at least ten ticks
        apb(1'b0, REG_REAL_TIME, 32'h0);
        chk({31'h0, r - t1 >= 32'h0000000A}, 32'h00000001, "real ran");
        for (i = 0; i < 16; i++)
        begin
            {m, sg, vg, dbl, rg} = 5'($urandom);
            {sc, vc, chs} = 7'($urandom);
            sync_gate_input <= sg;
            veto_gate_input <= vg;
            a = 16'h1000 + 16'($urandom_range(0, 24576));
            c = dbl ? a + 16'h1000 + 16'($urandom_range(0, 24576)) : a;
            if (i == 3)
                c = 16'hFFFF;
            b = dbl ? a - 16'h0800 : c;
            floor_lvl = (i == 5) ? c : 16'($urandom_range(0, 2048));
            apb(1'b1, REG_FLOOR, {16'h0, floor_lvl});
            apb(1'b1, REG_CTRL, {22'h0, vc, sc, chs, m, rg, 1'b1});
            apb(1'b0, REG_TOTAL, 32'h0);
            t0 = r;
            pulse(a, b, c);
            chk(atten_sel, rg, "range");
            rd(REG_TOTAL, t0 + npk(m, dbl, pass(sc, sg) && pass(vc, vg), a, c, floor_lvl),
                "count");
            rd(REG_LAST_PEAK, {16'h0, c}, "peak");
        end
        results;
    end
endmodule
